// ### cecb_pkg.sv
package cecb_pkg;
   localparam int unsigned AXI_AW = 12;
   localparam int unsigned ECC_DW = 120;
   localparam int unsigned EV_N   = 4;

   // Register indices, byte address is four times the index
   localparam logic [7:0] IX_GENERAL = 8'h10;
   localparam logic [7:0] IX_PINFN   = 8'h12;
   localparam logic [7:0] IX_ANGCHK  = 8'h13;
   localparam logic [7:0] IX_TALLY   = 8'h14;
   localparam logic [7:0] IX_H1A     = 8'h15;
   localparam logic [7:0] IX_H1P     = 8'h16;
   localparam logic [7:0] IX_H2A     = 8'h17;
   localparam logic [7:0] IX_H2P     = 8'h18;
   localparam logic [7:0] IX_H3A     = 8'h19;
   localparam logic [7:0] IX_H3P     = 8'h1a;
   localparam logic [7:0] IX_H8A     = 8'h1b;
   localparam logic [7:0] IX_H8P     = 8'h1c;
   localparam logic [7:0] IX_CODE    = 8'h1d;
   localparam logic [7:0] IX_SER0    = 8'h1e;
   localparam logic [7:0] IX_SER1    = 8'h1f;
   localparam logic [7:0] IX_SER2    = 8'h20;
   localparam logic [7:0] IX_IDW3    = 8'h21;
   localparam logic [7:0] IX_KEY     = 8'h23;
   localparam logic [7:0] IX_IST     = 8'h30;
   localparam logic [7:0] IX_IMASK   = 8'h31;
   localparam logic [7:0] IX_ESTAT   = 8'h32;

   localparam logic [15:0] RST_GENERAL = 16'h1230;
   localparam logic [15:0] RST_PINFN   = 16'h201f;
   localparam logic [15:0] RST_ANGCHK  = 16'h0000;
   localparam logic [15:0] RST_KEY     = 16'h4d54;
   localparam logic [15:0] KEY_DISABLE = 16'h4d54;

   localparam int unsigned H8SRC_BIT   = 10;
   localparam int unsigned PRODUCT_LSB  = 8;
   localparam int unsigned SUPPLY_LSB   = 6;
   localparam int unsigned REVISION_LSB = 0;

   localparam int unsigned EV_DONE  = 0;
   localparam int unsigned EV_ABORT = 1;
   localparam int unsigned EV_SGL   = 2;
   localparam int unsigned EV_DBL   = 3;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic              awvalid;
      logic [AXI_AW-1:0] awaddr;
      logic [2:0]        awprot;
      logic              wvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [AXI_AW-1:0] araddr;
      logic [2:0]        arprot;
      logic              rready;
   } cecb_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } cecb_axi_rsp_t;

   typedef struct packed {
      logic [10:0] h1_amp;
      logic [11:0] h1_ph;
      logic [10:0] h2_amp;
      logic [11:0] h2_ph;
      logic [7:0]  h3_amp;
      logic [11:0] h3_ph;
      logic [7:0]  h8_amp;
      logic [11:0] h8_ph;
   } cecb_coef_t;

   typedef struct packed {
      logic [ECC_DW-1:0] data;
      logic              sgl;
      logic              dbl;
   } cecb_ecc_t;

   // Hamming syndrome over non power-of-two columns
   function automatic logic [6:0] ecc_syn(input logic [ECC_DW-1:0] d);
      logic [6:0]  s;
      int unsigned n;
      s = '0;
      n = 0;
      for (int unsigned v = 3; v < 128; v++) begin
         if ((v & (v - 1)) != 0) begin
            if (d[n]) s = s ^ v[6:0];
            n = n + 1;
         end
      end
      return s;
   endfunction

   // Check, flag and repair one protected group
   function automatic cecb_ecc_t ecc_fix(input logic [ECC_DW-1:0] d,
                                         input logic [7:0] c);
      cecb_ecc_t   r;
      logic [6:0]  s;
      logic        p;
      int unsigned n;
      s = c[6:0] ^ ecc_syn(d);
      p = ^{d, c};
      r.data = d;
      r.sgl = p;
      r.dbl = !p && (s != 7'h00);
      n = 0;
      for (int unsigned v = 3; v < 128; v++) begin
         if ((v & (v - 1)) != 0) begin
            if (p && s == v[6:0]) r.data[n] = !d[n];
            n = n + 1;
         end
      end
      return r;
   endfunction
endpackage

// ### cecb_bank.sv
// How it works
// - Count up once per completed conversion
// - Aborted conversion leaves the tally unchanged
// - Tally wraps from full scale to zero
// - First, second amplitudes: 11-bit fields, rest reserved
// - Phase registers hold 12-bit unsigned fields
// - Third, eighth amplitudes: 8-bit fields only
// - Coefficient registers and tally reset to zero, eighth coefficient outputs to factory values
// - Config registers guarded by SEC-DED code
// - Code byte split: upper and lower groups
// - Key value turns correction off
// - Any other key value enables correction
// - Three read-only unique serial words
// - Identity word: product, supply, revision fields
// - Loader indicator is the pin default function
// - Source bit picks factory or user eighth coefficients
`timescale 1ns/1ps
`default_nettype none
module cecb_bank #(
   // Serial and identity defaults are arbitrary
   parameter logic [15:0] SER0        = 16'h1111,
   parameter logic [15:0] SER1        = 16'h2222,
   parameter logic [15:0] SER2        = 16'h3333,
   parameter logic [2:0]  PROD        = 3'h1,
   parameter logic [1:0]  SUPY        = 2'h1,
   parameter logic [2:0]  REVN        = 3'h1,
   parameter logic [7:0]  FACT_H8_AMP = 8'h00,
   parameter logic [11:0] FACT_H8_PH  = 12'h000
) (
   input  wire logic                   core_clk_i,
   input  wire logic                   arst_n_i,
   input  wire logic                   seq_start_i,
   input  wire logic                   seq_done_i,
   input  wire cecb_pkg::cecb_axi_req_t axi_req_i,
   output var  cecb_pkg::cecb_axi_rsp_t axi_rsp_o,
   output var  cecb_pkg::cecb_coef_t    coef_o,
   output logic [15:0]                 general_o,
   output logic [15:0]                 pin_fn_o,
   output logic [15:0]                 angle_chk_o,
   output logic                        ecc_fault_o,
   output logic                        irq_o
);
   import cecb_pkg::*;

   typedef struct packed {
      cecb_axi_rsp_t     rsp;
      logic              aw_held;
      logic [AXI_AW-1:0] aw_addr;
      logic              w_held;
      logic [15:0]       wdat;
      logic [1:0]        wbe;
      logic [7:0]        rd_ix;
      logic [15:0]       general;
      logic [15:0]       pinfn;
      logic [15:0]       angchk;
      logic [10:0]       h1a;
      logic [11:0]       h1p;
      logic [10:0]       h2a;
      logic [11:0]       h2p;
      logic [7:0]        h3a;
      logic [11:0]       h3p;
      logic [7:0]        h8a;
      logic [11:0]       h8p;
      logic [15:0]       code;
      logic [15:0]       key;
      logic [7:0]        tally;
      logic              busy;
      logic [EV_N-1:0]   ist;
      logic [EV_N-1:0]   imask;
      logic              irq;
      logic              fault;
      cecb_coef_t        coef;
      logic [15:0]       gen_o;
      logic [15:0]       pin_o;
      logic [15:0]       ang_o;
   } cecb_state_t;

   logic [1:0]        rst_sync_q;
   logic              rst_n;
   cecb_state_t       q;
   cecb_state_t       d;
   logic [ECC_DW-1:0] lo_raw;
   logic [ECC_DW-1:0] up_raw;
   logic [ECC_DW-1:0] lo_use;
   logic [ECC_DW-1:0] up_use;
   cecb_ecc_t         lo_chk;
   cecb_ecc_t         up_chk;
   logic              ecc_en;
   logic              sgl_err;
   logic              dbl_err;
   logic              done_ok;
   logic              abort_ev;
   logic              wr_go;
   logic [7:0]        wr_ix;
   logic [7:0]        ar_ix;
   logic [15:0]       wv;
   logic [EV_N-1:0]   ev_set;
   logic [EV_N-1:0]   ev_clr;
   logic [15:0]       idw;

   function automatic logic [15:0] merge16(input logic [15:0] o,
                                           input logic [15:0] n,
                                           input logic [1:0]  be);
      return {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
   endfunction

   function automatic logic mapped(input logic [AXI_AW-1:0] a);
      logic ok;
      ok = 1'b0;
      if (a[AXI_AW-1:10] == '0) begin
         unique case (a[9:2])
            IX_GENERAL, IX_PINFN, IX_ANGCHK, IX_TALLY, IX_H1A, IX_H1P,
            IX_H2A, IX_H2P, IX_H3A, IX_H3P, IX_H8A, IX_H8P, IX_CODE,
            IX_SER0, IX_SER1, IX_SER2, IX_IDW3, IX_KEY, IX_IST,
            IX_IMASK, IX_ESTAT: ok = 1'b1;
            default:            ok = 1'b0;
         endcase
      end
      return ok;
   endfunction

   // Current register contents as read by software
   function automatic logic [15:0] reg16(input logic [7:0] ix);
      logic [15:0] r;
      r = '0;
      unique case (ix)
         IX_GENERAL: r = q.general;
         IX_PINFN:   r = q.pinfn;
         IX_ANGCHK:  r = q.angchk;
         IX_TALLY:   r = {8'h00, q.tally};
         IX_H1A:     r = {5'h00, q.h1a};
         IX_H1P:     r = {4'h0, q.h1p};
         IX_H2A:     r = {5'h00, q.h2a};
         IX_H2P:     r = {4'h0, q.h2p};
         IX_H3A:     r = {8'h00, q.h3a};
         IX_H3P:     r = {4'h0, q.h3p};
         IX_H8A:     r = {8'h00, q.h8a};
         IX_H8P:     r = {4'h0, q.h8p};
         IX_CODE:    r = q.code;
         IX_SER0:    r = SER0;
         IX_SER1:    r = SER1;
         IX_SER2:    r = SER2;
         IX_IDW3:    r = idw;
         IX_KEY:     r = q.key;
         IX_IST:     r = {12'h000, q.ist};
         IX_IMASK:   r = {12'h000, q.imask};
         IX_ESTAT:   r = {13'h0000, dbl_err, sgl_err, ecc_en};
         default:    r = '0;
      endcase
      return r;
   endfunction

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   always_comb begin
      d = q;
      idw = '0;
      idw[PRODUCT_LSB +: 3] = PROD;
      idw[SUPPLY_LSB +: 2] = SUPY;
      idw[REVISION_LSB +: 3] = REVN;

      // Protected groups and their code bytes
      lo_raw = {18'h00000, q.general, q.pinfn, q.angchk, q.h1a,
                q.h1p, q.h2a, q.h2p, q.h3a};
      up_raw = {80'h0, 8'h00, q.h3p, q.h8a, q.h8p};
      lo_chk = ecc_fix(lo_raw, q.code[7:0]);
      up_chk = ecc_fix(up_raw, q.code[15:8]);
      ecc_en = q.key != KEY_DISABLE;
      sgl_err = ecc_en && (lo_chk.sgl || up_chk.sgl);
      dbl_err = ecc_en && (lo_chk.dbl || up_chk.dbl);
      lo_use = ecc_en ? lo_chk.data : lo_raw;
      up_use = ecc_en ? up_chk.data : up_raw;
      {d.gen_o, d.pin_o, d.ang_o, d.coef.h1_amp, d.coef.h1_ph,
       d.coef.h2_amp, d.coef.h2_ph, d.coef.h3_amp} = lo_use[101:0];
      d.coef.h3_ph = up_use[31:20];
      d.coef.h8_amp = FACT_H8_AMP;
      d.coef.h8_ph = FACT_H8_PH;
      if (lo_use[86 + H8SRC_BIT]) begin
         d.coef.h8_amp = up_use[19:12];
         d.coef.h8_ph = up_use[11:0];
      end
      d.fault = dbl_err;

      // Conversion tally
      done_ok = seq_done_i && q.busy;
      abort_ev = seq_start_i && q.busy && !seq_done_i;
      if (done_ok) begin
         d.tally = q.tally + 8'h01;
      end
      if (seq_start_i) begin
         d.busy = 1'b1;
      end else if (done_ok) begin
         d.busy = 1'b0;
      end

      // Write channel
      if (q.rsp.awready && axi_req_i.awvalid) begin
         d.aw_held = 1'b1;
         d.aw_addr = axi_req_i.awaddr;
      end
      if (q.rsp.wready && axi_req_i.wvalid) begin
         d.w_held = 1'b1;
         d.wdat = axi_req_i.wdata[15:0];
         d.wbe = axi_req_i.wstrb[1:0];
      end
      wr_go = q.aw_held && q.w_held && !q.rsp.bvalid;
      wr_ix = q.aw_addr[9:2];
      wv = merge16(reg16(wr_ix), q.wdat, q.wbe);
      ev_clr = '0;
      if (wr_go) begin
         d.aw_held = 1'b0;
         d.w_held = 1'b0;
         d.rsp.bvalid = 1'b1;
         d.rsp.bresp = mapped(q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
         if (q.aw_addr[AXI_AW-1:10] == '0) begin
            unique case (wr_ix)
               IX_GENERAL: d.general = wv;
               IX_PINFN:   d.pinfn = wv;
               IX_ANGCHK:  d.angchk = wv;
               IX_H1A:     d.h1a = wv[10:0];
               IX_H1P:     d.h1p = wv[11:0];
               IX_H2A:     d.h2a = wv[10:0];
               IX_H2P:     d.h2p = wv[11:0];
               IX_H3A:     d.h3a = wv[7:0];
               IX_H3P:     d.h3p = wv[11:0];
               IX_H8A:     d.h8a = wv[7:0];
               IX_H8P:     d.h8p = wv[11:0];
               IX_CODE:    d.code = wv;
               IX_KEY:     d.key = wv;
               IX_IMASK:   d.imask = wv[EV_N-1:0];
               IX_IST:     ev_clr = q.wdat[EV_N-1:0] & {EV_N{q.wbe[0]}};
               default:    d.rsp.bresp = d.rsp.bresp;
            endcase
         end
      end
      if (q.rsp.bvalid && axi_req_i.bready) begin
         d.rsp.bvalid = 1'b0;
      end
      d.rsp.awready = !d.aw_held && !d.rsp.bvalid;
      d.rsp.wready = !d.w_held && !d.rsp.bvalid;

      // Read channel
      ar_ix = axi_req_i.araddr[9:2];
      if (q.rsp.arready && axi_req_i.arvalid) begin
         d.rd_ix = ar_ix;
         d.rsp.rvalid = 1'b1;
         d.rsp.rdata = 32'h0;
         d.rsp.rresp = RESP_SLVERR;
         if (mapped(axi_req_i.araddr)) begin
            d.rsp.rdata = {16'h0000, reg16(ar_ix)};
            d.rsp.rresp = RESP_OKAY;
         end
      end else if (q.rsp.rvalid && axi_req_i.rready) begin
         d.rsp.rvalid = 1'b0;
      end
      d.rsp.arready = !d.rsp.rvalid;

      // Sticky events, set wins over clear
      ev_set = '0;
      ev_set[EV_DONE] = done_ok;
      ev_set[EV_ABORT] = abort_ev;
      ev_set[EV_SGL] = sgl_err;
      ev_set[EV_DBL] = dbl_err;
      d.ist = (q.ist & ~ev_clr) | ev_set;
      d.irq = |(d.ist & d.imask);
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.general <= RST_GENERAL;
         q.gen_o <= RST_GENERAL;
         q.pinfn <= RST_PINFN;
         q.pin_o <= RST_PINFN;
         q.angchk <= RST_ANGCHK;
         q.ang_o <= RST_ANGCHK;
         q.key <= RST_KEY;
         q.coef.h8_amp <= FACT_H8_AMP;
         q.coef.h8_ph <= FACT_H8_PH;
      end else begin
         q <= d;
      end
   end

   assign axi_rsp_o = q.rsp;
   assign coef_o = q.coef;
   assign general_o = q.gen_o;
   assign pin_fn_o = q.pin_o;
   assign angle_chk_o = q.ang_o;
   assign ecc_fault_o = q.fault;
   assign irq_o = q.irq;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n);

   tally_step_a: assert property (done_ok |=>
      q.tally == $past(q.tally) + 8'h01) else $error("tally step");
   tally_hold_a: assert property (abort_ev |=>
      $stable(q.tally)) else $error("tally moved on abort");
   tally_wrap_a: assert property (done_ok && q.tally == 8'hff
      |=> q.tally == 8'h00) else $error("tally wrap");
   amp_bits_a: assert property (q.rsp.rvalid
      && (q.rd_ix == IX_H1A || q.rd_ix == IX_H2A)
      |-> q.rsp.rdata[31:11] == '0) else $error("amp width");
   phase_bits_a: assert property (q.rsp.rvalid
      && (q.rd_ix == IX_H1P || q.rd_ix == IX_H8P)
      |-> q.rsp.rdata[31:12] == '0) else $error("phase width");
   amp8_bits_a: assert property (q.rsp.rvalid
      && (q.rd_ix == IX_H3A || q.rd_ix == IX_H8A)
      |-> q.rsp.rdata[31:8] == '0) else $error("amp8 width");
   reset_zero_a: assert property ($rose(rst_n)
      |-> q.tally == 8'h00 && q.h1a == '0 && q.h8p == '0
      && q.code == 16'h0000) else $error("reset not zero");
   code_write_a: assert property (wr_go && wr_ix == IX_CODE
      && q.aw_addr[AXI_AW-1:10] == '0
      && q.wbe == 2'b11 |=> q.code == $past(q.wdat))
      else $error("code store write");
   key_off_a: assert property (!ecc_en
      |=> !q.fault && q.coef.h1_ph == $past(q.h1p))
      else $error("correction not off");
   key_on_a: assert property (ecc_en
      |=> q.gen_o == $past(lo_chk.data[101:86]))
      else $error("correction not on");
   dbl_flag_a: assert property (dbl_err
      |=> ecc_fault_o && q.ist[EV_DBL]) else $error("double missed");
   serial_rd_a: assert property (q.rsp.rvalid
      && q.rd_ix == IX_SER0 |-> q.rsp.rdata[15:0] == SER0)
      else $error("serial word");
   id_word_a: assert property (q.rsp.rvalid
      && q.rd_ix == IX_IDW3 |-> q.rsp.rdata[15:0] == idw)
      else $error("identity word");
   boot_pin_a: assert property ($rose(rst_n)
      |-> pin_fn_o == RST_PINFN) else $error("pin default");
   h8_src_a: assert property (!ecc_en
      && !q.general[H8SRC_BIT] |=> q.coef.h8_amp == FACT_H8_AMP)
      else $error("h8 source");
   h8_user_a: assert property (!ecc_en
      && q.general[H8SRC_BIT] |=> q.coef.h8_amp == $past(q.h8a)
      && q.coef.h8_ph == $past(q.h8p)) else $error("h8 user source");
   tally_only_a: assert property (!done_ok
      |=> $stable(q.tally)) else $error("tally moved without done");
   done_flag_a: assert property (done_ok
      |=> q.ist[EV_DONE]) else $error("done flag missed");
   abort_flag_a: assert property (abort_ev
      |=> q.ist[EV_ABORT]) else $error("abort flag missed");
   sgl_fix_a: assert property (sgl_err && !dbl_err
      |=> !ecc_fault_o && q.ist[EV_SGL]) else $error("single fix");

   // Interrupt level and bus answer checks
   irq_level_a: assert property (irq_o == |(q.ist & q.imask))
      else $error("irq level");
   wr_answer_a: assert property (q.rsp.bvalid
      |-> !q.rsp.awready && !q.rsp.wready) else $error("write overlap");
   rd_answer_a: assert property (q.rsp.rvalid |-> !q.rsp.arready)
      else $error("read overlap");

   wrap_c: cover property (done_ok && q.tally == 8'hff);
   abort_c: cover property (abort_ev);
   fix_c: cover property (sgl_err ##1 irq_o);
   write_c: cover property (wr_go ##1 q.rsp.bvalid);
   dbl_c: cover property (dbl_err ##1 ecc_fault_o);
endmodule
`default_nettype wire

// ### cecb_host.sv
`timescale 1ns/1ps
`default_nettype none
module cecb_host (
   input  wire logic                    clk_i,
   input  wire cecb_pkg::cecb_axi_rsp_t rsp_i,
   output var  cecb_pkg::cecb_axi_req_t req_o
);
   import cecb_pkg::*;
   localparam int LIM = 200;
   int unsigned tmo = 0;
   initial req_o = '0;

   // Word write; each channel released once taken, payload then scrambled
   task automatic wr(input logic [7:0] ix, input logic [15:0] d,
                     output logic [1:0] r);
      int n;
      n = 0;
      r = 2'b11;
      @(posedge clk_i);
      req_o.awvalid <= 1'b1;
      req_o.awaddr  <= AXI_AW'({ix, 2'b00});
      req_o.wvalid  <= 1'b1;
      req_o.wdata   <= {16'h0000, d};
      req_o.wstrb   <= 4'hf;
      req_o.bready  <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
         if (req_o.awvalid && rsp_i.awready) begin
            req_o.awvalid <= 1'b0;
            req_o.awaddr  <= ~req_o.awaddr;
         end
         if (req_o.wvalid && rsp_i.wready) begin
            req_o.wvalid <= 1'b0;
            req_o.wdata  <= ~req_o.wdata;
         end
         if (rsp_i.bvalid) begin
            r = rsp_i.bresp;
            req_o.bready <= 1'b0;
         end
      end while (!rsp_i.bvalid && n < LIM);
      if (n >= LIM) tmo++;
   endtask

   // Word read; rready held until the answer is sampled
   task automatic rd(input logic [7:0] ix, output logic [31:0] d,
                     output logic [1:0] r);
      int n;
      n = 0;
      d = '0;
      r = 2'b11;
      @(posedge clk_i);
      req_o.arvalid <= 1'b1;
      req_o.araddr  <= AXI_AW'({ix, 2'b00});
      req_o.rready  <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
         if (req_o.arvalid && rsp_i.arready) begin
            req_o.arvalid <= 1'b0;
            req_o.araddr  <= ~req_o.araddr;
         end
         if (rsp_i.rvalid) begin
            d = rsp_i.rdata;
            r = rsp_i.rresp;
            req_o.rready <= 1'b0;
         end
      end while (!rsp_i.rvalid && n < LIM);
      if (n >= LIM) tmo++;
   endtask
endmodule
`default_nettype wire

// ### cecb_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import cecb_pkg::*;
   // Arbitrary serial and identity values
   localparam logic [15:0] SER0 = 16'h5a01;
   localparam logic [15:0] SER1 = 16'h6b02;
   localparam logic [15:0] SER2 = 16'h7c03;
   localparam logic [2:0]  PROD = 3'h5;
   localparam logic [1:0]  SUPY = 2'h2;
   localparam logic [2:0]  REVN = 3'h3;
   localparam logic [7:0]  F8A  = 8'h3c;
   localparam logic [11:0] F8P  = 12'h0c3;
   localparam logic [15:0] MSK [8] = '{16'h07ff, 16'h0fff, 16'h07ff,
      16'h0fff, 16'h00ff, 16'h0fff, 16'h00ff, 16'h0fff};
   logic          clk = 1'b0;
   logic          arst_n = 1'b0;
   logic          start = 1'b0;
   logic          done = 1'b0;
   cecb_axi_req_t req;
   cecb_axi_rsp_t rsp;
   cecb_coef_t    coef;
   logic [15:0]   gen;
   logic [15:0]   pfn;
   logic [15:0]   ang;
   logic          fault;
   logic          irq;
   logic [31:0]   rdat;
   logic [1:0]    resp;
   int unsigned   err_total = 0;
   int unsigned   num_checks = 0;

   always #50 clk = ~clk;

   cecb_bank #(.SER0(SER0), .SER1(SER1), .SER2(SER2), .PROD(PROD),
      .SUPY(SUPY), .REVN(REVN), .FACT_H8_AMP(F8A), .FACT_H8_PH(F8P)) DUT (
      .core_clk_i(clk), .arst_n_i(arst_n), .seq_start_i(start),
      .seq_done_i(done), .axi_req_i(req), .axi_rsp_o(rsp), .coef_o(coef),
      .general_o(gen), .pin_fn_o(pfn), .angle_chk_o(ang),
      .ecc_fault_o(fault), .irq_o(irq));

   cecb_host host (.clk_i(clk), .rsp_i(rsp), .req_o(req));

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask

   task automatic wreg(input logic [7:0] ix, input logic [15:0] d);
      host.wr(ix, d, resp);
      chk("bresp", {30'h0, RESP_OKAY}, {30'h0, resp});
      if (host.tmo != 0) final_report();
   endtask

   task automatic rreg(input logic [7:0] ix, input logic [15:0] e);
      host.rd(ix, rdat, resp);
      chk("rdata", {16'h0000, e}, rdat);
      chk("rresp", {30'h0, RESP_OKAY}, {30'h0, resp});
      if (host.tmo != 0) final_report();
   endtask

   // One-cycle pulse: 0 starts a sequence, 1 completes it
   task automatic pulse(input bit which);
      @(posedge clk);
      if (which) done <= 1'b1;
      else start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      done <= 1'b0;
   endtask

   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic final_report;
      err_total += host.tmo;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      repeat (6) @(posedge clk);
      for (int i = 20; i <= 29; i++) rreg(8'(i), 16'h0000);
      rreg(IX_SER0, SER0);
      rreg(IX_SER1, SER1);
      rreg(IX_SER2, SER2);
      rreg(IX_IDW3, {5'h00, PROD, SUPY, 3'h0, REVN});
      rreg(IX_PINFN, RST_PINFN);
      settle();
      chk("pin_fn", 32'h0, {31'h0, pfn[5]});
      chk("general", {16'h0, RST_GENERAL}, {16'h0, gen});
      chk("angle_chk", {16'h0, RST_ANGCHK}, {16'h0, ang});
      rreg(IX_ESTAT, 16'h0000);
      wreg(IX_SER0, 16'h0000);
      rreg(IX_SER0, SER0);
      wreg(IX_TALLY, 16'h00ff);
      rreg(IX_TALLY, 16'h0000);
      host.wr(8'h22, 16'h1234, resp);
      chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      host.rd(8'h22, rdat, resp);
      chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      chk("rdata", 32'h0, rdat);
      if (host.tmo != 0) final_report();
      for (int i = 0; i < 8; i++) begin
         wreg(8'(21 + i), 16'hffff);
         rreg(8'(21 + i), MSK[i]);
      end
      wreg(IX_H1A, 16'(int'(1000.0 * 0.6072)));
      rreg(IX_H1A, 16'd607);
      pulse(0);
      pulse(1);
      settle();
      rreg(IX_TALLY, 16'h0001);
      pulse(0);
      pulse(0);
      settle();
      rreg(IX_TALLY, 16'h0001);
      pulse(1);
      for (int i = 0; i < 253; i++) begin
         pulse(0);
         pulse(1);
      end
      settle();
      rreg(IX_TALLY, 16'h00ff);
      pulse(0);
      pulse(1);
      settle();
      rreg(IX_TALLY, 16'h0000);
      rreg(IX_IST, 16'h0003);
      wreg(IX_IMASK, 16'h0000);
      settle();
      chk("irq", 32'h0, {31'h0, irq});
      wreg(IX_IMASK, 16'h0001);
      settle();
      chk("irq", 32'h1, {31'h0, irq});
      wreg(IX_IST, 16'h0001);
      settle();
      chk("irq", 32'h0, {31'h0, irq});
      rreg(IX_IST, 16'h0002);
      wreg(IX_IST, 16'h0002);
      wreg(IX_H1A, 16'h0003);
      wreg(IX_H8A, 16'h005a);
      wreg(IX_H8P, 16'h0123);
      settle();
      chk("h1_amp", 32'h3, {21'h0, coef.h1_amp});
      chk("fault", 32'h0, {31'h0, fault});
      chk("h8_amp", {24'h0, F8A}, {24'h0, coef.h8_amp});
      chk("h8_ph", {20'h0, F8P}, {20'h0, coef.h8_ph});
      wreg(IX_GENERAL, 16'h0400);
      wreg(IX_ANGCHK, 16'h00a5);
      settle();
      chk("general", 32'h400, {16'h0, gen});
      chk("angle_chk", 32'ha5, {16'h0, ang});
      chk("h8_amp", 32'h5a, {24'h0, coef.h8_amp});
      chk("h8_ph", 32'h123, {20'h0, coef.h8_ph});
      wreg(IX_GENERAL, 16'h0000);
      for (int i = 18; i <= 28; i++) wreg(8'(i), 16'h0000);
      wreg(IX_CODE, 16'ha55a);
      rreg(IX_CODE, 16'ha55a);
      wreg(IX_CODE, 16'h0000);
      wreg(IX_KEY, 16'h0000);
      rreg(IX_ESTAT, 16'h0001);
      wreg(IX_IMASK, 16'h0004);
      wreg(IX_H1A, 16'h0004);
      settle();
      chk("h1_amp", 32'h0, {21'h0, coef.h1_amp});
      chk("irq", 32'h1, {31'h0, irq});
      chk("fault", 32'h0, {31'h0, fault});
      rreg(IX_ESTAT, 16'h0003);
      wreg(IX_H1A, 16'h0000);
      wreg(IX_H3P, 16'h0010);
      settle();
      chk("h3_ph", 32'h0, {20'h0, coef.h3_ph});
      wreg(IX_H3P, 16'h0030);
      settle();
      chk("fault", 32'h1, {31'h0, fault});
      rreg(IX_IST, 16'h000c);
      wreg(IX_KEY, KEY_DISABLE);
      settle();
      chk("fault", 32'h0, {31'h0, fault});
      chk("h3_ph", 32'h30, {20'h0, coef.h3_ph});
      final_report();
   end
endmodule
`default_nettype wire
